// *** rtcac_core.sv ***
// Real-time clock control, timebase divider, alarm and register file
`timescale 1ns/1ps
module rtcac_core #(
   parameter int WINDOW_CYC = 2
) (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output logic      [31:0] reg_rdata,
   input  wire logic        secondary_crystal_osc,
   input  wire logic        low_power_rc_osc,
   input  wire logic        external_timebase_pin,
   input  wire logic        peripheral_clock,
   output logic             clock_pin_out,
   output logic             clock_pin_oe
);
   if (WINDOW_CYC < 1 || WINDOW_CYC > 255) begin : g_window_check
      $error("WINDOW_CYC out of range");
   end

   // ------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------
   logic [31:0] ctrl1_q, ctrl2_q, atime_q, adate_q, time_q, date_q;
   logic        unlocked_q, half_q, alm_flag_q, pin_q, tb_prev_q;
   logic [15:0] div_cnt_q;
   logic [4:0]  frac_cnt_q;
   logic [7:0]  win_q;
   logic        edge_tick, underflow, tick_sec, alarm_hit, alarm_evt;
   logic        tb_level, wr_c1, guard, load_time, load_date;
   logic        on;
   logic [7:0]  rpt;

   assign on    = ctrl1_q[rtcac_pkg::C1_ON];
   assign guard = ctrl1_q[rtcac_pkg::C1_GUARD];
   assign rpt   = ctrl1_q[rtcac_pkg::C1_RPT_LO +: 8];
   assign wr_c1 = reg_wr && reg_addr == rtcac_pkg::OFF_CTRL1;

   // Timekeeping writes refused while guarded
   assign load_time = reg_wr && !guard && reg_addr == rtcac_pkg::OFF_TIME;
   assign load_date = reg_wr && !guard && reg_addr == rtcac_pkg::OFF_DATE;

   // ------------------------------------------------------------
   // Control registers
   // ------------------------------------------------------------
   // Unlock key arms one guard clear
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         unlocked_q <= 1'b0;
      end else if (reg_wr && reg_addr == rtcac_pkg::OFF_UNLOCK) begin
         unlocked_q <= reg_wdata == rtcac_pkg::UNLOCK_KEY;
      end else if (wr_c1) begin
         unlocked_q <= 1'b0;
      end
   end

   // Control one; hardware repeat decrement wins over software write
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl1_q <= rtcac_pkg::RST_ZERO;
      end else begin
         if (wr_c1) begin
            ctrl1_q <= reg_wdata & rtcac_pkg::C1_WMASK;
            if (guard && !reg_wdata[rtcac_pkg::C1_GUARD] && !unlocked_q) begin
               ctrl1_q[rtcac_pkg::C1_GUARD] <= 1'b1;
            end
         end
         if (alarm_evt) begin
            if (rpt != 8'h00 || ctrl1_q[rtcac_pkg::C1_CHIME]) begin
               ctrl1_q[rtcac_pkg::C1_RPT_LO +: 8] <= rpt - 8'h01;
            end else begin
               ctrl1_q[rtcac_pkg::C1_ARM] <= 1'b0;
            end
         end
      end
   end

   // Control two and alarm compare registers, guarded
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl2_q <= rtcac_pkg::RST_ZERO;
         atime_q <= rtcac_pkg::RST_ZERO;
         adate_q <= rtcac_pkg::RST_ZERO;
      end else if (reg_wr && !guard) begin
         case (reg_addr)
            rtcac_pkg::OFF_CTRL2: ctrl2_q <= reg_wdata & rtcac_pkg::C2_WMASK;
            rtcac_pkg::OFF_ATIME: atime_q <= reg_wdata & rtcac_pkg::TIME_MASK;
            rtcac_pkg::OFF_ADATE: adate_q <= reg_wdata & rtcac_pkg::DATE_MASK;
            default: ;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Timebase and divider
   // ------------------------------------------------------------
   always_comb begin
      case (ctrl2_q[1:0])
         rtcac_pkg::TB_PCLK: tb_level = peripheral_clock;
         rtcac_pkg::TB_PIN:  tb_level = external_timebase_pin;
         rtcac_pkg::TB_RCOSC: tb_level = low_power_rc_osc;
         default:            tb_level = secondary_crystal_osc;
      endcase
   end

   // Rising edge of selected timebase as an enable pulse
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) tb_prev_q <= 1'b0;
      else        tb_prev_q <= tb_level;
   end
   assign edge_tick = on && tb_level && !tb_prev_q;

   assign underflow = edge_tick && div_cnt_q == 16'h0000;

   // Reload counter; once per 16 s the period stretches by the fraction
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_q  <= 16'h0000;
         frac_cnt_q <= 5'h00;
      end else if (!on) begin
         div_cnt_q  <= ctrl2_q[rtcac_pkg::C2_DIV_LO +: 16];
         frac_cnt_q <= 5'h00;
      end else if (underflow) begin
         frac_cnt_q <= frac_cnt_q + 5'h01;
         if (frac_cnt_q == 5'(rtcac_pkg::HALVES_PER_FRAC - 1)) begin
            div_cnt_q <= ctrl2_q[rtcac_pkg::C2_DIV_LO +: 16]
                         + {11'h000, ctrl2_q[rtcac_pkg::C2_FR_LO +: 5]};
         end else begin
            div_cnt_q <= ctrl2_q[rtcac_pkg::C2_DIV_LO +: 16];
         end
      end else if (edge_tick) begin
         div_cnt_q <= div_cnt_q - 16'h0001;
      end
   end

   // Half-second phase
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)         half_q <= 1'b0;
      else if (underflow) half_q <= !half_q;
   end
   assign tick_sec = underflow && half_q;

   rtcac_bcd_time u_time (
      .core_clk  (core_clk),
      .rst_b     (rst_b),
      .tick_sec  (tick_sec),
      .load_time (load_time),
      .load_date (load_date),
      .wdata     (reg_wdata),
      .time_q    (time_q),
      .date_q    (date_q)
   );

   // ------------------------------------------------------------
   // Alarm
   // ------------------------------------------------------------
   function automatic logic alarm_match(input logic [3:0] m, input logic [31:0] t,
                                        input logic [31:0] a, input logic [31:0] d,
                                        input logic [31:0] ad, input logic h);
      case (m)
         4'h0: alarm_match = 1'b1;
         4'h1: alarm_match = !h;
         4'h2: alarm_match = !h && t[11:8] == a[11:8];
         4'h3: alarm_match = !h && t[15:8] == a[15:8];
         4'h4: alarm_match = !h && t[19:8] == a[19:8];
         4'h5: alarm_match = !h && t[23:8] == a[23:8];
         4'h6: alarm_match = !h && t[31:8] == a[31:8];
         4'h7: alarm_match = !h && t[31:8] == a[31:8] && d[2:0] == ad[2:0];
         4'h8: alarm_match = !h && t[31:8] == a[31:8] && d[13:8] == ad[13:8];
         4'h9: alarm_match = !h && t[31:8] == a[31:8] && d[20:8] == ad[20:8];
         default: alarm_match = 1'b0;
      endcase
   endfunction

   // Evaluated on every half-second boundary against the new time
   assign alarm_hit = alarm_match(ctrl1_q[rtcac_pkg::C1_MASK_LO +: 4], time_q, atime_q,
                                  date_q, adate_q, half_q);
   logic eval_q;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) eval_q <= 1'b0;
      else        eval_q <= underflow;
   end
   assign alarm_evt = eval_q && ctrl1_q[rtcac_pkg::C1_ARM] && alarm_hit;

   // Alarm flag set by event, cleared by hardware when disarmed
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)                             alm_flag_q <= 1'b0;
      else if (alarm_evt)                     alm_flag_q <= 1'b1;
      else if (!ctrl1_q[rtcac_pkg::C1_ARM])   alm_flag_q <= 1'b0;
   end

   // Update window following each half-second tick
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b)              win_q <= 8'h00;
      else if (underflow)      win_q <= 8'(WINDOW_CYC);
      else if (win_q != 8'h00) win_q <= win_q - 8'h01;
   end

   // ------------------------------------------------------------
   // Output pin
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         pin_q <= 1'b0;
      end else begin
         case (ctrl1_q[rtcac_pkg::C1_SEL_LO +: 3])
            rtcac_pkg::SEL_ALARM: pin_q <= alm_flag_q;
            rtcac_pkg::SEL_SEC:   pin_q <= half_q;
            rtcac_pkg::SEL_CLK:   pin_q <= half_q;
            default:              pin_q <= 1'b0;
         endcase
      end
   end
   assign clock_pin_out = ctrl1_q[rtcac_pkg::C1_OE] && pin_q;
   assign clock_pin_oe  = ctrl1_q[rtcac_pkg::C1_OE];

   // ------------------------------------------------------------
   // Read port
   // ------------------------------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            rtcac_pkg::OFF_CTRL1: reg_rdata <= ctrl1_q;
            rtcac_pkg::OFF_CTRL2: reg_rdata <= ctrl2_q;
            rtcac_pkg::OFF_STAT:  reg_rdata <= {26'h0, alm_flag_q, 2'h0, win_q != 8'h00,
                                                win_q != 8'h00, half_q};
            rtcac_pkg::OFF_TIME:  reg_rdata <= time_q;
            rtcac_pkg::OFF_DATE:  reg_rdata <= date_q;
            rtcac_pkg::OFF_ATIME: reg_rdata <= atime_q;
            rtcac_pkg::OFF_ADATE: reg_rdata <= adate_q;
            default:              reg_rdata <= 32'h0000_0000;
         endcase
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_guard_hold;
      @(posedge core_clk) disable iff (!rst_b)
      guard && !unlocked_q && wr_c1 |=> ctrl1_q[rtcac_pkg::C1_GUARD];
   endproperty
   a_guard_hold: assert property (p_guard_hold) else $error("guard cleared without unlock");

   property p_time_locked;
      @(posedge core_clk) disable iff (!rst_b)
      guard && !tick_sec |=> $stable(time_q);
   endproperty
   a_time_locked: assert property (p_time_locked) else $error("time changed while guarded");

   property p_rpt_dec;
      @(posedge core_clk) disable iff (!rst_b)
      alarm_evt && !wr_c1 && rpt != 8'h00 |=> rpt == $past(rpt) - 8'h01;
   endproperty
   a_rpt_dec: assert property (p_rpt_dec) else $error("repeat count not decremented");

   property p_rpt_stop;
      @(posedge core_clk) disable iff (!rst_b)
      alarm_evt && !wr_c1 && rpt == 8'h00 && !ctrl1_q[rtcac_pkg::C1_CHIME] |=> rpt == 8'h00;
   endproperty
   a_rpt_stop: assert property (p_rpt_stop) else $error("repeat count wrapped without chime");

   property p_off_still;
      @(posedge core_clk) disable iff (!rst_b)
      !on ##1 !on |-> !underflow && $stable(half_q);
   endproperty
   a_off_still: assert property (p_off_still) else $error("counting while disabled");

   property p_alm_flag;
      @(posedge core_clk) disable iff (!rst_b)
      alarm_evt |=> alm_flag_q;
   endproperty
   a_alm_flag: assert property (p_alm_flag) else $error("alarm flag not set");

   property p_pin_off;
      @(posedge core_clk) disable iff (!rst_b)
      !ctrl1_q[rtcac_pkg::C1_OE] |-> !clock_pin_oe && !clock_pin_out;
   endproperty
   a_pin_off: assert property (p_pin_off) else $error("pin driven while disabled");

   property p_half_toggle;
      @(posedge core_clk) disable iff (!rst_b)
      underflow |=> half_q != $past(half_q);
   endproperty
   a_half_toggle: assert property (p_half_toggle) else $error("phase did not toggle");

   property p_rpt_wrap;
      @(posedge core_clk) disable iff (!rst_b)
      alarm_evt && rpt == 8'h00 && ctrl1_q[rtcac_pkg::C1_CHIME] |=> rpt == 8'hff;
   endproperty
   a_rpt_wrap: assert property (p_rpt_wrap) else $error("no wrap with chime");

   property p_disarm;
      @(posedge core_clk) disable iff (!rst_b)
      alarm_evt && rpt == 8'h00 && !ctrl1_q[rtcac_pkg::C1_CHIME]
         |=> !ctrl1_q[rtcac_pkg::C1_ARM];
   endproperty
   a_disarm: assert property (p_disarm) else $error("alarm not disarmed at end");

   property p_frac_stretch;
      @(posedge core_clk) disable iff (!rst_b)
      underflow && frac_cnt_q == 5'(rtcac_pkg::HALVES_PER_FRAC - 1) |=>
         div_cnt_q == $past(ctrl2_q[rtcac_pkg::C2_DIV_LO +: 16])
                      + {11'h000, $past(ctrl2_q[rtcac_pkg::C2_FR_LO +: 5])};
   endproperty
   a_frac_stretch: assert property (p_frac_stretch) else $error("fraction not added");

   property p_rdata_idle;
      @(posedge core_clk) disable iff (!rst_b)
      !reg_rd |=> reg_rdata == 32'h0000_0000;
   endproperty
   a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");

   property p_pin_alarm;
      @(posedge core_clk) disable iff (!rst_b)
      ctrl1_q[rtcac_pkg::C1_SEL_LO +: 3] == rtcac_pkg::SEL_ALARM ##1 ctrl1_q[rtcac_pkg::C1_OE]
         |-> clock_pin_out == $past(alm_flag_q);
   endproperty
   a_pin_alarm: assert property (p_pin_alarm) else $error("pin not showing alarm");
endmodule

// *** rtcac_pkg.sv ***
// Package: register offsets, field positions, reset values, encodings
package rtcac_pkg;
   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL1  = 8'h00;
   localparam logic [7:0] OFF_CTRL2  = 8'h04;
   localparam logic [7:0] OFF_STAT   = 8'h08;
   localparam logic [7:0] OFF_TIME   = 8'h0c;
   localparam logic [7:0] OFF_DATE   = 8'h10;
   localparam logic [7:0] OFF_ATIME  = 8'h14;
   localparam logic [7:0] OFF_ADATE  = 8'h18;
   localparam logic [7:0] OFF_UNLOCK = 8'h1c;
   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int C1_ARM     = 31;
   localparam int C1_CHIME   = 30;
   localparam int C1_MASK_LO = 24;
   localparam int C1_RPT_LO  = 16;
   localparam int C1_ON      = 15;
   localparam int C1_GUARD   = 11;
   localparam int C1_OE      = 7;
   localparam int C1_SEL_LO  = 4;
   localparam int C2_DIV_LO  = 16;
   localparam int C2_FR_LO   = 11;
   localparam int ST_ALM     = 5;
   localparam int ST_SYNC    = 2;
   localparam int ST_ASYNC   = 1;
   localparam int ST_HALF    = 0;
   // ------------------------------------------------------------
   // Writable masks and reset values
   // ------------------------------------------------------------
   localparam logic [31:0] C1_WMASK  = 32'hcfff_88f0;
   localparam logic [31:0] C2_WMASK  = 32'hffff_f803;
   localparam logic [31:0] TIME_MASK = 32'h7f7f_ff00;
   localparam logic [31:0] DATE_MASK = 32'hff1f_3f07;
   localparam logic [31:0] RST_ZERO  = 32'h0000_0000;
   localparam logic [31:0] RST_DATE  = 32'h0001_0100;
   localparam logic [31:0] UNLOCK_KEY = 32'h0000_5a5a;
   // ------------------------------------------------------------
   // Encodings
   // ------------------------------------------------------------
   localparam logic [2:0] SEL_ALARM = 3'h0;
   localparam logic [2:0] SEL_SEC   = 3'h1;
   localparam logic [2:0] SEL_CLK   = 3'h2;
   localparam logic [1:0] TB_XTAL   = 2'h0;
   localparam logic [1:0] TB_RCOSC  = 2'h1;
   localparam logic [1:0] TB_PIN    = 2'h2;
   localparam logic [1:0] TB_PCLK   = 2'h3;
   localparam logic [3:0] AM_HALF   = 4'h0;
   localparam logic [3:0] AM_YEAR   = 4'h9;
   localparam int FRAC_PERIOD_S     = 16;
   localparam int HALVES_PER_FRAC   = 2 * FRAC_PERIOD_S;
endpackage

// *** rtcac_bcd_time.sv ***
// Packed decimal time and calendar counter with carries
`timescale 1ns/1ps
module rtcac_bcd_time (
   input  wire logic        core_clk,
   input  wire logic        rst_b,
   input  wire logic        tick_sec,
   input  wire logic        load_time,
   input  wire logic        load_date,
   input  wire logic [31:0] wdata,
   output logic      [31:0] time_q,
   output logic      [31:0] date_q
);
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   function automatic logic [7:0] bcd_inc(input logic [7:0] v);
      if (v[3:0] == 4'h9) begin
         bcd_inc = {v[7:4] + 4'h1, 4'h0};
      end else begin
         bcd_inc = {v[7:4], v[3:0] + 4'h1};
      end
   endfunction

   function automatic logic [7:0] month_days(input logic [7:0] m, input logic [7:0] y);
      case (m)
         8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
         8'h02: month_days = (y[4] ^ y[1]) == 1'b0 && y[0] == 1'b0 ? 8'h29 : 8'h28;
         default: month_days = 8'h31;
      endcase
   endfunction

   logic [7:0] hr, mn, sc, yr, mo, dy;
   logic [2:0] wd;
   assign hr = {1'b0, time_q[30:24]};
   assign mn = {1'b0, time_q[22:16]};
   assign sc = time_q[15:8];
   assign yr = date_q[31:24];
   assign mo = {3'h0, date_q[20:16]};
   assign dy = {2'h0, date_q[13:8]};
   assign wd = date_q[2:0];

   // Incremented digit pairs for the carry chain
   logic [7:0] mn_inc, hr_inc, mo_inc, dy_inc;
   assign mn_inc = bcd_inc(mn);
   assign hr_inc = bcd_inc(hr);
   assign mo_inc = bcd_inc(mo);
   assign dy_inc = bcd_inc(dy);

   // Counting, with software load taking priority
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         time_q <= rtcac_pkg::RST_ZERO;
         date_q <= rtcac_pkg::RST_DATE;
      end else if (load_time || load_date) begin
         if (load_time) time_q <= wdata & rtcac_pkg::TIME_MASK;
         if (load_date) date_q <= wdata & rtcac_pkg::DATE_MASK;
      end else if (tick_sec) begin
         time_q[15:8] <= (sc == 8'h59) ? 8'h00 : bcd_inc(sc);
         if (sc == 8'h59) begin
            time_q[22:16] <= (mn == 8'h59) ? 7'h00 : mn_inc[6:0];
            if (mn == 8'h59) begin
               time_q[30:24] <= (hr == 8'h23) ? 7'h00 : hr_inc[6:0];
               if (hr == 8'h23) begin
                  date_q[2:0] <= (wd == 3'h6) ? 3'h0 : wd + 3'h1;
                  if (dy == month_days(mo, yr)) begin
                     date_q[13:8] <= 6'h01;
                     date_q[20:16] <= (mo == 8'h12) ? 5'h01 : mo_inc[4:0];
                     if (mo == 8'h12) date_q[31:24] <= (yr == 8'h99) ? 8'h00 : bcd_inc(yr);
                  end else begin
                     date_q[13:8] <= dy_inc[5:0];
                  end
               end
            end
         end
      end
   end
endmodule

// *** tb_rtcac.sv ***
// Register-level testbench for the real-time clock control block
`timescale 1ns/1ps
module tb;
   // ------------------------------------------------------------
   // Signals and field constants
   // ------------------------------------------------------------
   logic        core_clk;
   logic        rst_b;
   logic [7:0]  reg_addr;
   logic [31:0] reg_wdata;
   logic        reg_wr;
   logic        reg_rd;
   logic [31:0] reg_rdata;
   logic [3:0]  tbase;
   logic        clock_pin_out;
   logic        clock_pin_oe;
   int          error_cnt;
   int          samples_checked;
   logic [31:0] d;
   logic        h;
   int          n;
   int          tot;
   localparam logic [31:0] B_ON  = 32'h1 << rtcac_pkg::C1_ON;
   localparam logic [31:0] B_OE  = 32'h1 << rtcac_pkg::C1_OE;
   localparam logic [31:0] B_ARM = 32'h1 << rtcac_pkg::C1_ARM;
   localparam logic [31:0] B_CHM = 32'h1 << rtcac_pkg::C1_CHIME;
   localparam logic [31:0] B_GRD = 32'h1 << rtcac_pkg::C1_GUARD;
   localparam logic [31:0] ONES  = 32'hffff_ffff;

   // Device under test, sync window widened so reads can see it
   rtcac_core #(.WINDOW_CYC(20)) uut (
      .core_clk              (core_clk),
      .rst_b                 (rst_b),
      .reg_addr              (reg_addr),
      .reg_wdata             (reg_wdata),
      .reg_wr                (reg_wr),
      .reg_rd                (reg_rd),
      .reg_rdata             (reg_rdata),
      .secondary_crystal_osc (tbase[0]),
      .low_power_rc_osc      (tbase[1]),
      .external_timebase_pin (tbase[2]),
      .peripheral_clock      (tbase[3]),
      .clock_pin_out         (clock_pin_out),
      .clock_pin_oe          (clock_pin_oe)
   );

   // ------------------------------------------------------------
   // Clock, bus tasks and checks
   // ------------------------------------------------------------
   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge core_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr    <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] v);
      @(posedge core_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd   <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      samples_checked++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      rd(a, d);
      chk(nm, e, d);
   endtask

   // One rising edge per count on timebase input k
   task automatic pulse(input int k, input int cnt);
      repeat (cnt) begin
         @(posedge core_clk);
         tbase[k] <= 1'b1;
         repeat (2) @(posedge core_clk);
         tbase[k] <= 1'b0;
         repeat (2) @(posedge core_clk);
      end
   endtask

   // Edges on input k until the half-second phase flips, bounded
   task automatic edges(input int k, output int cnt);
      logic p;
      rd(rtcac_pkg::OFF_STAT, d);
      p = d[0];
      cnt = 0;
      do begin
         pulse(k, 1);
         cnt++;
         rd(rtcac_pkg::OFF_STAT, d);
      end while (d[0] === p && cnt < 200);
      if (cnt >= 200) begin
         error_cnt++;
         $display("BAD half phase expected toggle seen none");
         print_verdict();
      end
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (100000) @(posedge core_clk);
      error_cnt++;
      $display("BAD run length expected finish seen hang");
      print_verdict();
   end

   // ------------------------------------------------------------
   // Main sequence
   // ------------------------------------------------------------
   initial begin
      rst_b = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      tbase = 4'h0;
      error_cnt = 0;
      samples_checked = 0;
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      // Reset values, unmapped place
      rchk("ctrl1 reset", rtcac_pkg::OFF_CTRL1, 32'h0);
      rchk("ctrl2 reset", rtcac_pkg::OFF_CTRL2, 32'h0);
      rchk("status reset", rtcac_pkg::OFF_STAT, 32'h0);
      rchk("date reset", rtcac_pkg::OFF_DATE, rtcac_pkg::RST_DATE);
      wr(8'h20, ONES);
      rchk("unmapped", 8'h20, 32'h0);
      $display("test reset done");
      // Write guard and unlock
      wr(rtcac_pkg::OFF_CTRL1, ONES);
      rchk("ctrl1 mask", rtcac_pkg::OFF_CTRL1, rtcac_pkg::C1_WMASK);
      wr(rtcac_pkg::OFF_CTRL1, 32'h0);
      rchk("guard kept", rtcac_pkg::OFF_CTRL1, B_GRD);
      wr(rtcac_pkg::OFF_CTRL2, ONES);
      rchk("ctrl2 locked", rtcac_pkg::OFF_CTRL2, 32'h0);
      wr(rtcac_pkg::OFF_TIME, 32'h1259_5900);
      rchk("time locked", rtcac_pkg::OFF_TIME, 32'h0);
      wr(rtcac_pkg::OFF_STAT, ONES);
      rchk("status ro", rtcac_pkg::OFF_STAT, 32'h0);
      wr(rtcac_pkg::OFF_UNLOCK, rtcac_pkg::UNLOCK_KEY);
      wr(rtcac_pkg::OFF_CTRL1, 32'h0);
      rchk("guard cleared", rtcac_pkg::OFF_CTRL1, 32'h0);
      wr(rtcac_pkg::OFF_CTRL2, ONES);
      rchk("ctrl2 mask", rtcac_pkg::OFF_CTRL2, rtcac_pkg::C2_WMASK);
      $display("test guard done");
      // Divider, half phase, sync window and time carries
      wr(rtcac_pkg::OFF_CTRL2, (32'd3 << rtcac_pkg::C2_DIV_LO) | 32'(rtcac_pkg::TB_PCLK));
      wr(rtcac_pkg::OFF_CTRL1, B_ON);
      edges(3, n);
      h = d[0];
      wr(rtcac_pkg::OFF_TIME, 32'h1259_5900);
      rchk("time layout", rtcac_pkg::OFF_TIME, 32'h1259_5900);
      pulse(3, 4);
      rchk("status tick", rtcac_pkg::OFF_STAT, {29'h0, 2'b11, ~h});
      pulse(3, 4);
      rchk("status half", rtcac_pkg::OFF_STAT, {29'h0, 2'b11, h});
      rchk("time carry", rtcac_pkg::OFF_TIME, 32'h1300_0000);
      repeat (30) @(posedge core_clk);
      rchk("sync clear", rtcac_pkg::OFF_STAT, {31'h0, h});
      wr(rtcac_pkg::OFF_CTRL1, 32'h0);
      pulse(3, 8);
      rchk("stopped", rtcac_pkg::OFF_STAT, {31'h0, h});
      $display("test divider done");
      // Every timebase source, pin driving seconds clock
      for (int k = 0; k < 4; k++) begin
         wr(rtcac_pkg::OFF_CTRL2, (32'd3 << rtcac_pkg::C2_DIV_LO) | 32'(k));
         wr(rtcac_pkg::OFF_CTRL1, B_ON | B_OE | (32'(rtcac_pkg::SEL_SEC) << rtcac_pkg::C1_SEL_LO));
         pulse(k ^ 1, 4);
         rd(rtcac_pkg::OFF_STAT, d);
         chk("other source", {31'h0, h}, {31'h0, d[0]});
         pulse(k, 4);
         h = ~h;
         rd(rtcac_pkg::OFF_STAT, d);
         chk("own source", {31'h0, h}, {31'h0, d[0]});
         chk("pin seconds", {30'h0, 1'b1, h}, {30'h0, clock_pin_oe, clock_pin_out});
      end
      wr(rtcac_pkg::OFF_CTRL1, B_ON | B_OE | (32'(rtcac_pkg::SEL_ALARM) << rtcac_pkg::C1_SEL_LO));
      repeat (2) @(negedge core_clk);
      chk("pin alarm", 32'h2, {30'h0, clock_pin_oe, clock_pin_out});
      wr(rtcac_pkg::OFF_CTRL1, B_ON);
      #1 chk("pin off", 32'h0, {30'h0, clock_pin_oe, clock_pin_out});
      $display("test sources done");
      // Alarm every half second: count down, disarm at end, chime wrap
      wr(rtcac_pkg::OFF_CTRL1, B_ON | B_ARM | B_OE | (32'h1 << rtcac_pkg::C1_RPT_LO));
      edges(3, n);
      chk("alarm flag", 32'h1, {31'h0, d[rtcac_pkg::ST_ALM]});
      chk("pin alarm event", 32'h3, {30'h0, clock_pin_oe, clock_pin_out});
      rchk("repeat down", rtcac_pkg::OFF_CTRL1, B_ON | B_ARM | B_OE);
      edges(3, n);
      chk("alarm flag off", 32'h0, {31'h0, d[rtcac_pkg::ST_ALM]});
      rchk("repeat end", rtcac_pkg::OFF_CTRL1, B_ON | B_OE);
      wr(rtcac_pkg::OFF_CTRL1, B_ON | B_ARM | B_CHM);
      edges(3, n);
      rchk("repeat wrap", rtcac_pkg::OFF_CTRL1,
           B_ON | B_ARM | B_CHM | (32'hff << rtcac_pkg::C1_RPT_LO));
      wr(rtcac_pkg::OFF_CTRL1, B_ON);
      $display("test alarm done");
      // Fractional trim: 32 half seconds of two edges hold one stretched period
      for (int f = 0; f < 32; f += 31) begin
         wr(rtcac_pkg::OFF_CTRL2, (32'd1 << rtcac_pkg::C2_DIV_LO)
            | (32'(f) << rtcac_pkg::C2_FR_LO) | 32'(rtcac_pkg::TB_PCLK));
         edges(3, n);
         tot = 0;
         repeat (32) begin
            edges(3, n);
            tot += n;
         end
         chk("trim edges", 32'(rtcac_pkg::HALVES_PER_FRAC * 2 + f), 32'(tot));
      end
      $display("test trim done");
      print_verdict();
   end
endmodule
